// *** src/bridge_window_pkg.sv ***
// Constants, register map and carrier types for the bridge window registers.
// Assumes a byte-offset register port with 32-bit data on one clock.
package bridge_window_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets (byte offsets, narrow registers sit in the low bits)
    localparam logic [7:0] OFS_PF_LOW = 8'h24;
    localparam logic [7:0] OFS_PF_HIGH = 8'h26;
    localparam logic [7:0] OFS_PF_LOW_UP = 8'h28;
    localparam logic [7:0] OFS_PF_HIGH_UP = 8'h2C;
    localparam logic [7:0] OFS_IO_LOW_UP = 8'h30;
    localparam logic [7:0] OFS_IO_HIGH_UP = 8'h32;

    // Field positions inside the two 16-bit prefetchable registers
    localparam int CAP_BIT = 0;
    localparam int FIELD_LSB = 4;
    localparam int FIELD_MSB = 15;

    // Reset values
    localparam logic RST_WIDE_PF = 1'h1;
    localparam logic [11:0] RST_PF_LOW = 12'hFFF;
    localparam logic [11:0] RST_PF_HIGH = 12'h000;
    localparam logic [31:0] RST_PF_LOW_UP = 32'hFFFFFFFF;
    localparam logic [31:0] RST_PF_HIGH_UP = 32'h00000000;
    localparam logic [15:0] RST_IO_LOW_UP = 16'hFFFF;
    localparam logic [15:0] RST_IO_HIGH_UP = 16'h0000;

    // Implied low address bits of each bound
    localparam logic [19:0] PF_LOW_FILL = 20'h00000;
    localparam logic [19:0] PF_HIGH_FILL = 20'hFFFFF;
    localparam logic [11:0] IO_LOW_FILL = 12'h000;
    localparam logic [11:0] IO_HIGH_FILL = 12'hFFF;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [63:0] low;
        logic [63:0] high;
    } pf_bounds_t;

    typedef struct packed {
        logic [31:0] low;
        logic [31:0] high;
    } io_bounds_t;

    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction : reg_hit

endpackage : bridge_window_pkg

// *** src/window_match.sv ***
// Registered inclusive range check of one address against a window.
// Assumes bounds and address are stable flops on the same clock.
`timescale 1ns/1ps
module window_match #(
    parameter int W = 64
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] low,
    input wire logic [W-1:0] high,
    input wire logic [W-1:0] addr,
    output logic hit_r
);

    logic hit_nxt;

    // An inverted window (low above high) never matches, which closes it
    always_comb begin
        hit_nxt = (addr >= low) && (addr <= high);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hit_r <= 1'b0;
        end else begin
            hit_r <= hit_nxt;
        end
    end

endmodule : window_match

// *** src/bridge_prefetch_io_window_regs.sv ***
// Prefetchable window registers and upper I/O window halves of a bridge port.
// Assumes a single-cycle strobe register port and lower I/O fields from local logic.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module bridge_prefetch_io_window_regs (
    input wire logic clk,
    input wire logic rstn,
    input bridge_window_pkg::reg_req_t req,
    output logic [31:0] rdata,
    input wire logic wide_io_support,
    input wire logic [3:0] io_window_low_bound,
    input wire logic [3:0] io_window_high_bound,
    input wire logic [63:0] pf_query_addr,
    input wire logic [31:0] io_query_addr,
    output bridge_window_pkg::pf_bounds_t pf_bounds,
    output bridge_window_pkg::io_bounds_t io_bounds,
    output logic wide_prefetch_addressing,
    output logic pf_hit,
    output logic io_hit
);

    logic wide_prefetch_support_r;
    logic [11:0] prefetch_window_low_bound_r;
    logic [11:0] prefetch_window_high_bound_r;
    logic [31:0] prefetch_low_bound_upper_half_r;
    logic [31:0] prefetch_high_bound_upper_half_r;
    logic [15:0] io_low_bound_upper_half_r;
    logic [15:0] io_high_bound_upper_half_r;

    logic wr_pf_low;
    logic wr_pf_high;
    logic wr_pf_low_up;
    logic wr_pf_high_up;
    logic wr_io_low_up;
    logic wr_io_high_up;

    logic [31:0] pf_low_up_eff;
    logic [31:0] pf_high_up_eff;
    logic [15:0] io_low_up_eff;
    logic [15:0] io_high_up_eff;

    logic [31:0] rdata_nxt;
    bridge_window_pkg::pf_bounds_t pf_bounds_nxt;
    bridge_window_pkg::io_bounds_t io_bounds_nxt;

    // Write decode
    always_comb begin
        wr_pf_low = req.wr && bridge_window_pkg::reg_hit(req.addr, bridge_window_pkg::OFS_PF_LOW);
        wr_pf_high = req.wr &&
            bridge_window_pkg::reg_hit(req.addr, bridge_window_pkg::OFS_PF_HIGH);
        wr_pf_low_up = req.wr &&
            bridge_window_pkg::reg_hit(req.addr, bridge_window_pkg::OFS_PF_LOW_UP);
        wr_pf_high_up = req.wr &&
            bridge_window_pkg::reg_hit(req.addr, bridge_window_pkg::OFS_PF_HIGH_UP);
        wr_io_low_up = req.wr &&
            bridge_window_pkg::reg_hit(req.addr, bridge_window_pkg::OFS_IO_LOW_UP);
        wr_io_high_up = req.wr &&
            bridge_window_pkg::reg_hit(req.addr, bridge_window_pkg::OFS_IO_HIGH_UP);
    end

    // Capability bit, software writable after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wide_prefetch_support_r <= bridge_window_pkg::RST_WIDE_PF;
        end else if (wr_pf_low) begin
            wide_prefetch_support_r <= req.wdata[bridge_window_pkg::CAP_BIT];
        end
    end

    // Only bits 15:4 are stored; bits 3:1 have no flops at all
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prefetch_window_low_bound_r <= bridge_window_pkg::RST_PF_LOW;
        end else if (wr_pf_low) begin
            prefetch_window_low_bound_r <=
                req.wdata[bridge_window_pkg::FIELD_MSB:bridge_window_pkg::FIELD_LSB];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prefetch_window_high_bound_r <= bridge_window_pkg::RST_PF_HIGH;
        end else if (wr_pf_high) begin
            prefetch_window_high_bound_r <=
                req.wdata[bridge_window_pkg::FIELD_MSB:bridge_window_pkg::FIELD_LSB];
        end
    end

    // Upper halves are cleared while their capability is off, so re-enabling
    // the capability never exposes a stale value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prefetch_low_bound_upper_half_r <= bridge_window_pkg::RST_PF_LOW_UP;
        end else if (!wide_prefetch_support_r) begin
            prefetch_low_bound_upper_half_r <= '0;
        end else if (wr_pf_low_up) begin
            prefetch_low_bound_upper_half_r <= req.wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prefetch_high_bound_upper_half_r <= bridge_window_pkg::RST_PF_HIGH_UP;
        end else if (!wide_prefetch_support_r) begin
            prefetch_high_bound_upper_half_r <= '0;
        end else if (wr_pf_high_up) begin
            prefetch_high_bound_upper_half_r <= req.wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            io_low_bound_upper_half_r <= bridge_window_pkg::RST_IO_LOW_UP;
        end else if (!wide_io_support) begin
            io_low_bound_upper_half_r <= '0;
        end else if (wr_io_low_up) begin
            io_low_bound_upper_half_r <= req.wdata[15:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            io_high_bound_upper_half_r <= bridge_window_pkg::RST_IO_HIGH_UP;
        end else if (!wide_io_support) begin
            io_high_bound_upper_half_r <= '0;
        end else if (wr_io_high_up) begin
            io_high_bound_upper_half_r <= req.wdata[15:0];
        end
    end

    // Masking covers the one cycle before the clear above lands
    always_comb begin
        pf_low_up_eff = wide_prefetch_support_r ?
            prefetch_low_bound_upper_half_r : '0;
        pf_high_up_eff = wide_prefetch_support_r ?
            prefetch_high_bound_upper_half_r : '0;
        io_low_up_eff = wide_io_support ? io_low_bound_upper_half_r : '0;
        io_high_up_eff = wide_io_support ? io_high_bound_upper_half_r : '0;
    end

    // Read mux; unmapped offsets and idle cycles give zero
    always_comb begin
        rdata_nxt = '0;
        if (req.rd) begin
            case (req.addr)
                bridge_window_pkg::OFS_PF_LOW: begin
                    rdata_nxt = {16'h0000, prefetch_window_low_bound_r, 3'h0,
                        wide_prefetch_support_r};
                end
                bridge_window_pkg::OFS_PF_HIGH: begin
                    rdata_nxt = {16'h0000, prefetch_window_high_bound_r, 3'h0,
                        wide_prefetch_support_r};
                end
                bridge_window_pkg::OFS_PF_LOW_UP: begin
                    rdata_nxt = pf_low_up_eff;
                end
                bridge_window_pkg::OFS_PF_HIGH_UP: begin
                    rdata_nxt = pf_high_up_eff;
                end
                bridge_window_pkg::OFS_IO_LOW_UP: begin
                    rdata_nxt = {16'h0000, io_low_up_eff};
                end
                bridge_window_pkg::OFS_IO_HIGH_UP: begin
                    rdata_nxt = {16'h0000, io_high_up_eff};
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else begin
            rdata <= rdata_nxt;
        end
    end

    // Assembled bounds for forwarding decode
    always_comb begin
        pf_bounds_nxt.low = {pf_low_up_eff, prefetch_window_low_bound_r,
            bridge_window_pkg::PF_LOW_FILL};
        pf_bounds_nxt.high = {pf_high_up_eff, prefetch_window_high_bound_r,
            bridge_window_pkg::PF_HIGH_FILL};
        io_bounds_nxt.low = {io_low_up_eff, io_window_low_bound, bridge_window_pkg::IO_LOW_FILL};
        io_bounds_nxt.high = {io_high_up_eff, io_window_high_bound,
            bridge_window_pkg::IO_HIGH_FILL};
    end

    // Registered so the decode path starts from flops, at one cycle of latency
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pf_bounds.low <= {bridge_window_pkg::RST_PF_LOW_UP, bridge_window_pkg::RST_PF_LOW,
                bridge_window_pkg::PF_LOW_FILL};
            pf_bounds.high <= {bridge_window_pkg::RST_PF_HIGH_UP, bridge_window_pkg::RST_PF_HIGH,
                bridge_window_pkg::PF_HIGH_FILL};
            // I/O bounds follow live inputs, so they start at zero until the first edge
            io_bounds <= '0;
            wide_prefetch_addressing <= bridge_window_pkg::RST_WIDE_PF;
        end else begin
            pf_bounds <= pf_bounds_nxt;
            io_bounds <= io_bounds_nxt;
            wide_prefetch_addressing <= wide_prefetch_support_r;
        end
    end

    window_match #(
        .W(64)
    ) pf_match (
        .clk(clk),
        .rstn(rstn),
        .low(pf_bounds.low),
        .high(pf_bounds.high),
        .addr(pf_query_addr),
        .hit_r(pf_hit)
    );

    window_match #(
        .W(32)
    ) io_match (
        .clk(clk),
        .rstn(rstn),
        .low(io_bounds.low),
        .high(io_bounds.high),
        .addr(io_query_addr),
        .hit_r(io_hit)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    AST_CAP_WRITE: assert property (
        wr_pf_low |=> ##1 wide_prefetch_addressing == $past(req.wdata[0], 2)
    ) else $error("capability bit not taken from write");

    AST_LIMIT_MIRROR: assert property (
        req.rd && req.addr == bridge_window_pkg::OFS_PF_HIGH
        |=> rdata[0] == $past(wide_prefetch_support_r)
    ) else $error("high bound bit 0 does not mirror capability");

    AST_BASE_FIELD: assert property (
        wr_pf_low |=> ##1 pf_bounds.low[31:0] == {$past(req.wdata[15:4], 2), 20'h00000}
    ) else $error("prefetch base field not assembled");

    AST_LIMIT_FIELD: assert property (
        wr_pf_high |=> ##1 pf_bounds.high[31:0] == {$past(req.wdata[15:4], 2), 20'hFFFFF}
    ) else $error("prefetch limit field not assembled");

    // Gated by rstn so the edge that releases reset does not judge a held flop
    AST_PF_DECIDE: assert property (
        rstn |=> pf_hit == ($past(pf_query_addr) >= $past(pf_bounds.low) &&
            $past(pf_query_addr) <= $past(pf_bounds.high))
    ) else $error("prefetch hit disagrees with bounds");

    AST_BASE_UPPER: assert property (
        wr_pf_low_up && wide_prefetch_support_r
        |=> ##1 pf_bounds.low[63:32] == $past(req.wdata, 2)
    ) else $error("base upper half not applied");

    AST_LIMIT_UPPER: assert property (
        wr_pf_high_up && wide_prefetch_support_r
        |=> ##1 pf_bounds.high[63:32] == $past(req.wdata, 2)
    ) else $error("limit upper half not applied");

    AST_PF_UPPER_LOCK: assert property (
        !wide_prefetch_support_r && req.rd &&
        (req.addr == bridge_window_pkg::OFS_PF_LOW_UP ||
         req.addr == bridge_window_pkg::OFS_PF_HIGH_UP)
        |=> rdata == 32'h00000000
    ) else $error("prefetch upper half visible while narrow");

    AST_PF_UPPER_DROP: assert property (
        !wide_prefetch_support_r
        |=> prefetch_low_bound_upper_half_r == 32'h00000000 &&
            prefetch_high_bound_upper_half_r == 32'h00000000
    ) else $error("prefetch upper half kept a value while narrow");

    AST_IO_UPPER_WRITE: assert property (
        wr_io_low_up && wide_io_support
        |=> io_low_bound_upper_half_r == $past(req.wdata[15:0])
    ) else $error("io base upper half not written");

    AST_IO_HIGH_UPPER: assert property (
        wr_io_high_up && wide_io_support
        |=> io_high_bound_upper_half_r == $past(req.wdata[15:0])
    ) else $error("io limit upper half not written");

    AST_IO_UPPER_LOCK: assert property (
        !wide_io_support && req.rd &&
        (req.addr == bridge_window_pkg::OFS_IO_LOW_UP ||
         req.addr == bridge_window_pkg::OFS_IO_HIGH_UP)
        |=> rdata == 32'h00000000
    ) else $error("io upper half visible while narrow");

    AST_IO_UPPER_DROP: assert property (
        !wide_io_support
        |=> io_low_bound_upper_half_r == 16'h0000 &&
            io_high_bound_upper_half_r == 16'h0000
    ) else $error("io upper half kept a value while narrow");

    AST_IO_LIMIT: assert property (
        rstn |=> io_bounds.high[15:0] == {$past(io_window_high_bound), 12'hFFF}
    ) else $error("io limit low bits not all ones");

    AST_RSVD_ZERO: assert property (
        req.rd && (req.addr == bridge_window_pkg::OFS_PF_LOW ||
                   req.addr == bridge_window_pkg::OFS_PF_HIGH)
        |=> rdata[3:1] == 3'h0 && rdata[31:16] == 16'h0000
    ) else $error("reserved bits not zero");

    AST_NARROW_BOUNDS: assert property (
        !wide_prefetch_support_r |=> pf_bounds.low[63:32] == 32'h00000000 &&
            pf_bounds.high[63:32] == 32'h00000000
    ) else $error("upper bounds not zero in narrow mode");

    AST_RDATA_IDLE: assert property (
        !req.rd |=> rdata == 32'h00000000
    ) else $error("read data not zero after an idle cycle");

    COV_PF_HIT: cover property (pf_hit);
    COV_IO_HIT: cover property (io_hit && wide_io_support);
    COV_IO_NARROW: cover property (!wide_io_support && wr_io_high_up);
    COV_NARROW: cover property (wr_pf_low && !req.wdata[0] ##1 !wide_prefetch_support_r);
    COV_UPPER_READ: cover property (req.rd && req.addr == bridge_window_pkg::OFS_PF_LOW_UP
        && wide_prefetch_support_r);

endmodule : bridge_prefetch_io_window_regs

// *** bench/test_bridge_prefetch_io_window_regs.sv ***
// Self-checking bench for the prefetchable and upper I/O window registers.
// Assumes the register port contract of the block and one 200 MHz clock.
`timescale 1ns/1ps
module test_bridge_prefetch_io_window_regs;
    logic clk;
    logic rstn;
    bridge_window_pkg::reg_req_t req;
    logic [31:0] rdata;
    logic wide_io_support;
    logic [3:0] io_window_low_bound;
    logic [3:0] io_window_high_bound;
    logic [63:0] pf_query_addr;
    logic [31:0] io_query_addr;
    bridge_window_pkg::pf_bounds_t pf_bounds;
    bridge_window_pkg::io_bounds_t io_bounds;
    logic wide_prefetch_addressing;
    logic pf_hit;
    logic io_hit;
    int fail_count;
    int compares;

    bridge_prefetch_io_window_regs bridge_prefetch_io_window_regs_i (
        .clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
        .wide_io_support(wide_io_support),
        .io_window_low_bound(io_window_low_bound),
        .io_window_high_bound(io_window_high_bound),
        .pf_query_addr(pf_query_addr), .io_query_addr(io_query_addr),
        .pf_bounds(pf_bounds), .io_bounds(io_bounds),
        .wide_prefetch_addressing(wide_prefetch_addressing),
        .pf_hit(pf_hit), .io_hit(io_hit)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("mismatches %0d, comparisons %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // Each access task ends with an idle cycle so the strobe never changes twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
        @(posedge clk);
        req <= '0;
        #1;
        chk(rdata, exp, "read data");
        @(posedge clk);
    endtask : rd

    task automatic wr_then_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
        @(posedge clk);
        req <= '0;
        #1;
        chk(rdata, exp, "read after write");
        @(posedge clk);
    endtask : wr_then_rd

    task automatic qry(input logic [63:0] p, input logic [31:0] i, input logic ep,
                       input logic ei);
        pf_query_addr <= p;
        io_query_addr <= i;
        @(posedge clk);
        #1;
        chk(pf_hit, ep, "prefetch hit");
        chk(io_hit, ei, "io hit");
        @(posedge clk);
    endtask : qry

    task automatic reset_dut;
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask : reset_dut

    task automatic scen_reset_values;
        repeat (2) @(posedge clk);
        #1;
        chk(wide_prefetch_addressing, 1'b1, "cap after reset");
        chk(pf_bounds.low, 64'hFFFFFFFF_FFF00000, "pf low after reset");
        chk(pf_bounds.high, 64'h00000000_000FFFFF, "pf high after reset");
        chk(io_bounds.low, 32'hFFFF2000, "io low after reset");
        chk(io_bounds.high, 32'h00007FFF, "io high after reset");
        @(posedge clk);
        rd(8'h24, 32'h0000FFF1);
        rd(8'h26, 32'h00000001);
        rd(8'h28, 32'hFFFFFFFF);
        rd(8'h2C, 32'h00000000);
        rd(8'h30, 32'h0000FFFF);
        rd(8'h32, 32'h00000000);
    endtask : scen_reset_values

    task automatic scen_fields;
        wr(8'h24, 32'hFFFF123F);
        rd(8'h24, 32'h00001231);
        wr(8'h26, 32'hFFFF5676);
        rd(8'h26, 32'h00005671);
    endtask : scen_fields

    task automatic scen_wide_window;
        wr_then_rd(8'h28, 32'h00000001, 32'h00000001);
        wr_then_rd(8'h2C, 32'h00000002, 32'h00000002);
        #1;
        chk(pf_bounds.low, 64'h00000001_12300000, "pf low assembled");
        chk(pf_bounds.high, 64'h00000002_567FFFFF, "pf high assembled");
        @(posedge clk);
        qry(64'h00000001_12300000, 32'h0, 1'b1, 1'b0);
        qry(64'h00000001_122FFFFF, 32'h0, 1'b0, 1'b0);
        qry(64'h00000002_567FFFFF, 32'h0, 1'b1, 1'b0);
        qry(64'h00000002_56800000, 32'h0, 1'b0, 1'b0);
    endtask : scen_wide_window

    task automatic scen_narrow_mode;
        wr(8'h24, 32'h00001230);
        rd(8'h26, 32'h00005670);
        rd(8'h28, 32'h00000000);
        wr(8'h28, 32'h00001234);
        rd(8'h28, 32'h00000000);
        wr(8'h2C, 32'h00005678);
        rd(8'h2C, 32'h00000000);
        #1;
        chk(wide_prefetch_addressing, 1'b0, "cap cleared");
        chk(pf_bounds.low, 64'h00000000_12300000, "pf low narrow");
        chk(pf_bounds.high, 64'h00000000_567FFFFF, "pf high narrow");
        @(posedge clk);
        qry(64'h00000000_12300000, 32'h0, 1'b1, 1'b0);
        qry(64'h00000001_12300000, 32'h0, 1'b0, 1'b0);
        // Re-enabling shows the cleared upper half, then writes land again
        wr(8'h24, 32'h00001231);
        rd(8'h28, 32'h00000000);
        wr_then_rd(8'h28, 32'hDEADBEEF, 32'hDEADBEEF);
    endtask : scen_narrow_mode

    task automatic scen_io_window;
        wr(8'h30, 32'h12345678);
        rd(8'h30, 32'h00005678);
        wr_then_rd(8'h32, 32'h00009ABC, 32'h00009ABC);
        #1;
        chk(io_bounds.low, 32'h56782000, "io low assembled");
        chk(io_bounds.high, 32'h9ABC7FFF, "io high assembled");
        @(posedge clk);
        qry(64'h0, 32'h56782000, 1'b0, 1'b1);
        qry(64'h0, 32'h56781FFF, 1'b0, 1'b0);
        qry(64'h0, 32'h9ABC7FFF, 1'b0, 1'b1);
        qry(64'h0, 32'h9ABC8000, 1'b0, 1'b0);
        wide_io_support <= 1'b0;
        @(posedge clk);
        rd(8'h30, 32'h00000000);
        wr(8'h32, 32'h00001111);
        rd(8'h32, 32'h00000000);
        #1;
        chk(io_bounds.low, 32'h00002000, "io low narrow");
        chk(io_bounds.high, 32'h00007FFF, "io high narrow");
        @(posedge clk);
        wide_io_support <= 1'b1;
        @(posedge clk);
    endtask : scen_io_window

    task automatic scen_unmapped;
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h00000000);
        rd(8'h34, 32'h00000000);
        // Read data must drop back to zero in the cycle after it stands
        req <= '{wr: 1'b0, rd: 1'b1, addr: 8'h24, wdata: 32'h00000000};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        #1;
        chk(rdata, 32'h00000000, "read data after its cycle");
        @(posedge clk);
    endtask : scen_unmapped

    initial begin
        fail_count = 0;
        compares = 0;
        rstn = 1'b0;
        req = '0;
        wide_io_support = 1'b1;
        io_window_low_bound = 4'h2;
        io_window_high_bound = 4'h7;
        pf_query_addr = 64'h0;
        io_query_addr = 32'h0;
        reset_dut();
        scen_reset_values();
        scen_fields();
        scen_wide_window();
        scen_narrow_mode();
        scen_io_window();
        scen_unmapped();
        // A second reset mid-run must restore every register
        reset_dut();
        scen_reset_values();
        give_verdict();
    end

    // The sequence needs about 130 cycles; this limit of 4000 cycles is far beyond that
    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end
endmodule : test_bridge_prefetch_io_window_regs
